// ==== rtl/qeo_pkg.sv ====
// Package with constants for the quadrature encoder output stage.
package qeo_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned OFFSET_COMP_MS  = 50;
    // Longest time rounds down to whole cycles.
    localparam int unsigned OFFSET_COMP_CYC = (OFFSET_COMP_MS * 1000000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Angle and hysteresis
    // ------------------------------------------------------------------
    localparam int unsigned ANGLE_W         = 8;
    localparam int unsigned FINE_W          = 9;
    // Hysteresis of 0.7 degrees is half of one 1.4 degree step, one fine LSB.
    localparam logic [8:0]  HYST_FINE       = 9'h0_001;
    localparam logic [7:0]  ZERO_ANGLE      = 8'h0_0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic        RST_OUT_LEVEL   = 1'b1;

    // ------------------------------------------------------------------
    // Output stage states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        QEO_ST_COMP = 2'b00,
        QEO_ST_DIAG = 2'b01,
        QEO_ST_RUN  = 2'b10
    } qeo_state_e;

endpackage : qeo_pkg

// ==== rtl/qeo_sync.sv ====
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/10ps
module qeo_sync
    import qeo_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output logic      sync_o
);

    logic meta_q;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : qeo_sync

// ==== rtl/qeo_top.sv ====
// Quadrature and index output stage with power-up diagnostic and field flags.
// Behaviour
// - With chip select low at power-up, outputs start only after offset compensation, under 50 ms.
// - With chip select high at power-up, A, B and index are all forced high and held.
// - In normal running A, B and index are never all high, and index high means A and B low.
// - Pulling chip select low leaves the all-high state, and outputs stay enabled after it rises.
// - The field-rising flag pulls low while field strength is increasing.
// - The field-falling flag pulls low while field strength is decreasing.
// - With the field out of range both flags pull low together.
// - With the field in range and steady both flag transistors are off.
// - A and B give 64 quadrature cycles per turn, 256 edges, one per angle step.
// - Exactly one index pulse is given per turn, at the zero angle.
// - Clockwise rotation makes A lead B by 90 degrees, counter-clockwise makes B lead A.
// - The index pulse lasts exactly one angle step.
// - After a reversal outputs hold until the movement back exceeds 0.7 degrees of hysteresis.
`timescale 1ns/10ps
module qeo_top
    import qeo_pkg::*;
#(
    parameter int unsigned COMP_CYCLES = OFFSET_COMP_CYC
) (
    input  wire logic               ref_clk_i,
    input  wire logic               reset_n_i,
    input  wire logic [FINE_W-1:0]  angle_fine_i,
    input  wire logic               comp_done_i,
    input  wire logic               chip_select_low_n_i,
    input  wire logic               field_rising_i,
    input  wire logic               field_falling_i,
    input  wire logic               field_bad_i,
    output logic                    chan_a_o,
    output logic                    chan_b_o,
    output logic                    index_o,
    output logic                    field_rising_flag_o,
    output logic                    field_rising_flag_oe_o,
    output logic                    field_falling_flag_o,
    output logic                    field_falling_flag_oe_o,
    output logic [1:0]              run_state_o
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic cs_n_s;

    // Chip select has a pull-up, so it is taken as high while in reset.
    qeo_sync #(.RST_VAL(1'b1)) u_cs_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (chip_select_low_n_i),
        .sync_o    (cs_n_s)
    );

    // ------------------------------------------------------------------
    // Offset compensation timer
    // ------------------------------------------------------------------
    logic [31:0] comp_cnt_q;
    logic        comp_end;

    assign comp_end = comp_done_i || (comp_cnt_q >= COMP_CYCLES - 1);

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            comp_cnt_q <= 32'h0000_0000;
        end else if (!comp_end) begin
            comp_cnt_q <= comp_cnt_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Enable state machine
    // ------------------------------------------------------------------
    qeo_state_e state_q;
    logic       cs_seen_q;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cs_seen_q <= 1'b0;
        end else if (!cs_n_s) begin
            cs_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= QEO_ST_COMP;
        end else begin
            unique case (state_q)
                QEO_ST_COMP: begin
                    if (comp_end) begin
                        state_q <= (cs_seen_q || !cs_n_s) ? QEO_ST_RUN : QEO_ST_DIAG;
                    end
                end
                QEO_ST_DIAG: begin
                    if (!cs_n_s) begin
                        state_q <= QEO_ST_RUN;
                    end
                end
                QEO_ST_RUN: begin
                    state_q <= QEO_ST_RUN;
                end
                default: begin
                    state_q <= QEO_ST_COMP;
                end
            endcase
        end
    end

    assign run_state_o = state_q;

    // ------------------------------------------------------------------
    // Hysteresis tracker on the fine angle
    // ------------------------------------------------------------------
    // The fine angle has half-step resolution; the output angle only moves
    // back once the reverse travel exceeds one fine LSB.
    logic [FINE_W-1:0] fine_q;
    logic [ANGLE_W-1:0] pos_q;
    logic              dir_cw_q;
    logic [FINE_W-1:0] delta;

    assign delta = angle_fine_i - fine_q;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            fine_q   <= 9'h0_000;
            dir_cw_q <= 1'b1;
        end else if (delta != 9'h0_000) begin
            if (!delta[FINE_W-1]) begin
                if (dir_cw_q || delta > HYST_FINE) begin
                    fine_q   <= angle_fine_i;
                    dir_cw_q <= 1'b1;
                end
            end else if (!dir_cw_q || (fine_q - angle_fine_i) > HYST_FINE) begin
                fine_q   <= angle_fine_i;
                dir_cw_q <= 1'b0;
            end
        end
    end

    // Forward the angle shifted by the half step on counter-clockwise travel.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pos_q <= ZERO_ANGLE;
        end else begin
            pos_q <= dir_cw_q ? fine_q[FINE_W-1:1] : 8'(fine_q[FINE_W-1:1] + fine_q[0]);
        end
    end

    // ------------------------------------------------------------------
    // Gray decode and output registers
    // ------------------------------------------------------------------
    function automatic logic [1:0] qeo_gray(input logic [1:0] b);
        qeo_gray = {b[1], b[1] ^ b[0]};
    endfunction : qeo_gray

    logic [1:0] quad;
    logic       idx_hit;

    assign quad    = qeo_gray(pos_q[1:0]);
    assign idx_hit = (pos_q == ZERO_ANGLE);

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            chan_a_o <= RST_OUT_LEVEL;
            chan_b_o <= RST_OUT_LEVEL;
            index_o  <= RST_OUT_LEVEL;
        end else if (state_q == QEO_ST_RUN) begin
            // Channel A takes the low Gray bit, so it moves first while the angle rises.
            chan_a_o <= idx_hit ? 1'b0 : quad[0];
            chan_b_o <= idx_hit ? 1'b0 : quad[1];
            index_o  <= idx_hit;
        end else begin
            chan_a_o <= RST_OUT_LEVEL;
            chan_b_o <= RST_OUT_LEVEL;
            index_o  <= RST_OUT_LEVEL;
        end
    end

    // ------------------------------------------------------------------
    // Field flags, open drain
    // ------------------------------------------------------------------
    logic rise_s;
    logic fall_s;
    logic bad_s;

    qeo_sync u_rise_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (field_rising_i),
        .sync_o    (rise_s)
    );

    qeo_sync u_fall_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (field_falling_i),
        .sync_o    (fall_s)
    );

    qeo_sync u_bad_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (field_bad_i),
        .sync_o    (bad_s)
    );

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            field_rising_flag_oe_o  <= 1'b0;
            field_falling_flag_oe_o <= 1'b0;
        end else begin
            field_rising_flag_oe_o  <= bad_s || (rise_s && !fall_s);
            field_falling_flag_oe_o <= bad_s || (fall_s && !rise_s);
        end
    end

    assign field_rising_flag_o  = 1'b0;
    assign field_falling_flag_o = 1'b0;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_NO_ALL_HIGH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $past(state_q) == QEO_ST_RUN && state_q == QEO_ST_RUN |-> !(chan_a_o && chan_b_o && index_o))
        else $error("All outputs high while running.");

    AST_INDEX_QUAD_LOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $past(state_q) == QEO_ST_RUN && index_o |-> !chan_a_o && !chan_b_o)
        else $error("Quadrature high during index.");

    AST_DIAG_HIGH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        state_q == QEO_ST_DIAG |=> chan_a_o && chan_b_o && index_o)
        else $error("Diagnostic state did not hold outputs high.");

    AST_RUN_STICKY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        state_q == QEO_ST_RUN |=> state_q == QEO_ST_RUN)
        else $error("Run state left.");

    AST_CS_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        state_q == QEO_ST_DIAG && !cs_n_s |=> state_q == QEO_ST_RUN)
        else $error("Chip select low did not enable outputs.");

    AST_BAD_BOTH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        bad_s |=> field_rising_flag_oe_o && field_falling_flag_oe_o)
        else $error("Out of range field did not set both flags.");

    AST_RISE_ONLY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rise_s && !fall_s && !bad_s |=> field_rising_flag_oe_o && !field_falling_flag_oe_o)
        else $error("Rising field flag wrong.");

    AST_FALL_ONLY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        fall_s && !rise_s && !bad_s |=> field_falling_flag_oe_o && !field_rising_flag_oe_o)
        else $error("Falling field flag wrong.");

    AST_STEADY_OFF: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !rise_s && !fall_s && !bad_s |=> !field_rising_flag_oe_o && !field_falling_flag_oe_o)
        else $error("Flags on with steady good field.");

    AST_INDEX_ZERO: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        state_q == QEO_ST_RUN && $past(state_q) == QEO_ST_RUN |=> index_o == $past(idx_hit))
        else $error("Index not at zero angle.");

endmodule : qeo_top

// ==== testbench/qeo_reader.sv ====
// Reader model: pulled-up flag lines and a quadrature edge and index counter.
`timescale 1ns/10ps
module qeo_reader (
    input  wire logic ref_clk_i,
    input  wire logic chan_a_i,
    input  wire logic chan_b_i,
    input  wire logic index_i,
    input  wire logic rise_i,
    input  wire logic rise_oe_i,
    input  wire logic fall_i,
    input  wire logic fall_oe_i,
    output logic      tied_o,
    output int        edges_o,
    output int        index_o,
    output int        ilen_o,
    output logic      a_leads_o
);
    logic a_q;
    logic b_q;
    logic i_q;
    // Both flags share one pull-up, so either transistor pulls the line low.
    assign tied_o = (rise_oe_i ? rise_i : 1'b1) & (fall_oe_i ? fall_i : 1'b1);
    // The counters are two-state and start at zero; ilen_o is the length of the latest index pulse.
    always @(posedge ref_clk_i) begin
        if (chan_a_i !== a_q) begin
            edges_o++;
            a_leads_o = (chan_a_i !== chan_b_i);
        end
        if (chan_b_i !== b_q) begin
            edges_o++;
            a_leads_o = (chan_b_i === chan_a_i);
        end
        if (index_i === 1'b1 && i_q === 1'b0) begin
            index_o++;
            ilen_o = 0;
        end
        if (index_i === 1'b1) begin
            ilen_o++;
        end
        a_q = chan_a_i;
        b_q = chan_b_i;
        i_q = index_i;
    end
endmodule : qeo_reader

// ==== testbench/tb.sv ====
// Self-checking bench for the quadrature encoder output stage.
`timescale 1ns/10ps
module tb
    import qeo_pkg::*;
();
    localparam int unsigned COMP = 20;
    logic              clk;
    logic              rst_n;
    logic [FINE_W-1:0] angle;
    logic              done;
    logic              cs_n;
    logic [2:0]        fld;
    logic              a, b, i, rf, rf_oe, ff, ff_oe, tied, lead;
    logic [1:0]        st;
    logic [5:0]        pins;
    int                edges, idx, ilen, c, n_mismatch, n_checks;
    int                row_n [6] = '{0, 2, 2, 2, 2, -16};
    logic [2:0]        row_f [6] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h6, 3'h0};
    logic [5:0]        row_e [6] = '{6'h01, 6'h14, 6'h1a, 6'h0e, 6'h01, 6'h21};
    assign pins = {i, a, b, rf_oe, ff_oe, tied};

    qeo_top #(.COMP_CYCLES(COMP)) qeo_top_inst (
        .ref_clk_i(clk), .reset_n_i(rst_n), .angle_fine_i(angle), .comp_done_i(done),
        .chip_select_low_n_i(cs_n), .field_rising_i(fld[2]), .field_falling_i(fld[1]),
        .field_bad_i(fld[0]), .chan_a_o(a), .chan_b_o(b), .index_o(i),
        .field_rising_flag_o(rf), .field_rising_flag_oe_o(rf_oe), .field_falling_flag_o(ff),
        .field_falling_flag_oe_o(ff_oe), .run_state_o(st));
    qeo_reader qeo_reader_inst (
        .ref_clk_i(clk), .chan_a_i(a), .chan_b_i(b), .index_i(i), .rise_i(rf),
        .rise_oe_i(rf_oe), .fall_i(ff), .fall_oe_i(ff_oe), .tied_o(tied),
        .edges_o(edges), .index_o(idx), .ilen_o(ilen), .a_leads_o(lead));

    always #5 clk = ~clk;

    task automatic end_of_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic bad(input logic [31:0] got, input logic [31:0] exp);
        n_mismatch++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    endtask : bad
    task automatic chk_bits(input logic [5:0] got, input logic [5:0] exp);
        n_checks++;
        if (got !== exp) bad(got, exp);
    endtask : chk_bits
    task automatic chk_st(input logic [1:0] exp);
        n_checks++;
        if (st !== exp) bad(st, exp);
    endtask : chk_st
    task automatic chk_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) bad(got, exp);
    endtask : chk_cnt
    // Waits end on the falling edge so that registered outputs have settled.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic wait_st(input logic [1:0] s, input int lim);
        c = 0;
        while (st !== s) begin
            @(negedge clk);
            c++;
            if (c > lim) begin
                n_mismatch++;
                end_of_test();
            end
        end
    endtask : wait_st
    // The angle moves one fine step per cycle so every output edge is clean.
    task automatic move(input int n);
        logic [8:0] v;
        v = angle;
        for (int k = 0; k < (n < 0 ? -n : n); k++) begin
            @(posedge clk);
            v = (n < 0) ? v - 9'h001 : v + 9'h001;
            angle <= v;
        end
        cyc(5);
    endtask : move
    task automatic turn(input int n, input logic up);
        int e0;
        int i0;
        e0 = edges;
        i0 = idx;
        move(n);
        chk_cnt(edges - e0, 256);
        chk_cnt(idx - i0, 1);
        // One angle step is two half steps, so two cycles at the bench's pace.
        chk_cnt(ilen, 2);
        chk_bits({5'h00, lead}, {5'h00, up});
    endtask : turn
    task automatic restart(input logic cs, input logic dn);
        @(posedge clk);
        rst_n <= 1'b0;
        cs_n <= cs;
        done <= dn;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
    endtask : restart

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        angle = 9'h000;
        done = 1'b0;
        cs_n = 1'b1;
        fld = 3'h0;
        n_mismatch = 0;
        n_checks = 0;
        restart(1'b1, 1'b0);
        chk_st(2'h0);
        wait_st(2'h1, 40);
        cyc(2);
        chk_bits(pins, 6'h39);
        move(8);
        chk_bits(pins, 6'h39);
        @(posedge clk);
        cs_n <= 1'b0;
        wait_st(2'h2, 10);
        cyc(3);
        @(posedge clk);
        cs_n <= 1'b1;
        cyc(5);
        chk_st(2'h2);
        for (int r = 0; r < 6; r++) begin
            @(posedge clk);
            fld <= row_f[r];
            move(row_n[r]);
            chk_bits(pins, row_e[r]);
        end
        move(8);
        move(-1);
        chk_bits(pins, 6'h01);
        move(-1);
        chk_bits(pins, 6'h09);
        turn(-512, 1'b0);
        turn(512, 1'b1);
        restart(1'b0, 1'b0);
        chk_st(2'h0);
        chk_bits(pins, 6'h39);
        wait_st(2'h2, 40);
        chk_cnt(c >= 10, 1);
        restart(1'b1, 1'b1);
        wait_st(2'h1, 8);
        end_of_test();
    end
endmodule : tb
